// *** design/lan_host_pkg.sv ***
// Constants and types for the host bus port
package lan_host_pkg;
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_ISR = 4'h7;
   localparam logic [3:0] REG_REMOTE_LO = 4'h8;
   localparam logic [3:0] REG_REMOTE_HI = 4'h9;
   localparam logic [3:0] REG_TCR = 4'hD;
   localparam logic [3:0] REG_DCR = 4'hE;
   localparam logic [3:0] REG_IMR = 4'hF;
   localparam int CMD_STOP_BIT = 0;
   localparam int CMD_START_BIT = 1;
   localparam int DCR_LONG_ADDR_BIT = 3;
   localparam int ISR_RX_BIT = 0;
   localparam int ISR_TX_BIT = 1;
   localparam int ISR_DMA_BIT = 6;
   localparam logic [7:0] CMD_RST = 8'h01;
   localparam logic [7:0] IMR_RST = 8'h00;
   localparam logic [7:0] DCR_RST = 8'h00;
   localparam logic [7:0] TCR_RST = 8'h00;
   localparam logic [7:0] ISR_RST = 8'h00;
   localparam logic [7:0] RSAR_RST = 8'h00;
   localparam int RESET_MAX_CYC = 10;
   localparam int BUF_DEPTH = 2;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
   } reg_wr_t;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_SYNC = 2'b01,
      S_ACK = 2'b10
   } slv_st_t;
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_T1 = 3'b001,
      D_T2 = 3'b010,
      D_T3 = 3'b011,
      D_TW = 3'b100,
      D_T4 = 3'b101
   } dma_st_t;
   typedef enum logic [1:0] {
      K_LOCAL = 2'b00,
      K_RWR = 2'b01,
      K_RRD = 2'b10
   } dma_kind_t;
endpackage : lan_host_pkg

// *** design/lan_host_port.sv ***
// Host bus port: slave registers, DMA arbitration, remote latch handshake
// Operation
// RULE1 - Slave write stores bus data in register
// RULE2 - Slave read returns selected register contents
// RULE3 - Acknowledge held off until access synchronised
// RULE4 - Register select ignored while chip select high
// RULE5 - Port read enabled during remote write cycle
// RULE6 - Write acknowledge starts local memory write
// RULE7 - Events interrupt; status write clears them
// RULE8 - Each interrupt source maskable
// RULE9 - Reset stops traffic until start bit
// RULE10 - Reset initialises command, mask, config registers
// RULE11 - Reset completes within ten bus clocks
// RULE12 - Bus request raised when FIFO needs service
// RULE13 - No master cycle before bus grant
// RULE14 - Permanent grant tie deadlocks; loop request instead
// RULE15 - Long address mode strobes upper address
// RULE16 - Upper strobe floats until bus grant
// RULE17 - Short mode pin is port request
// RULE18 - Shared pin floats until config programmed
// RULE19 - Ready high at t3 extends cycle
// RULE20 - Chip select qualifies whole slave access
// RULE21 - Memory cycle is t1 to t4
// RULE22 - Read acknowledge starts latch refill read
// RULE23 - Acknowledge released when strobe removed
`timescale 1ns/1ps
`default_nettype none
module lan_host_port (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic CS_N,
   input wire logic SLAVE_WRITE_STROBE_N,
   input wire logic SLAVE_READ_STROBE_N,
   input wire logic [3:0] REGISTER_SELECT,
   input wire logic [7:0] AD_IN,
   output logic [7:0] AD_OUT,
   output logic AD_OE,
   output logic ACK_N,
   input wire logic EV_RX,
   input wire logic EV_TX,
   input wire logic EV_DMA,
   output logic INT,
   output logic TXRX_ENABLE,
   input wire logic FIFO_REQ,
   input wire logic REMOTE_ACTIVE,
   output logic BUS_REQUEST,
   input wire logic BACK,
   input wire logic READY,
   input wire logic LATCH_WRITE_ACK,
   input wire logic LATCH_READ_ACK,
   output logic PORT_READ_ENABLE,
   output logic SHARED_PIN_O,
   output logic SHARED_PIN_OE,
   output logic [15:0] UPPER_ADDR,
   output logic [1:0] DMA_KIND,
   output logic DMA_DONE
);
   lan_host_pkg::slv_st_t slv_q, slv_d;
   lan_host_pkg::dma_st_t dma_q, dma_d;
   lan_host_pkg::dma_kind_t kind_q, kind_d;
   lan_host_pkg::reg_wr_t acc_q, buf_q [lan_host_pkg::BUF_DEPTH];
   logic rd_q;
   logic [7:0] cmd_q, isr_q, imr_q, dcr_q, tcr_q, remote_lo_q, remote_hi_q;
   logic [7:0] isr_d, isr_clr, isr_set;
   logic dcr_prog_q;
   logic wr_pend_q, rd_pend_q;
   logic wptr_q, rptr_q;
   logic [1:0] cnt_q;

   function automatic logic [7:0] rd_mux(input logic [3:0] sel,
      input logic [7:0] c, i, m, d, t, r0, r1);
      logic [7:0] v;
      v = 8'h00;
      unique case (sel)
         lan_host_pkg::REG_CMD: v = c;
         lan_host_pkg::REG_ISR: v = i;
         lan_host_pkg::REG_IMR: v = m;
         lan_host_pkg::REG_DCR: v = d;
         lan_host_pkg::REG_TCR: v = t;
         lan_host_pkg::REG_REMOTE_LO: v = r0;
         lan_host_pkg::REG_REMOTE_HI: v = r1;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : rd_mux

   // Slave access decode
   wire strobe_on = !SLAVE_WRITE_STROBE_N || !SLAVE_READ_STROBE_N;
   wire acc_start = !CS_N && strobe_on; // [RULE4] [RULE20]
   wire acc_end = CS_N || !strobe_on; // [RULE20]
   wire buf_rdy = cnt_q != 2'd2;
   // Aborted writes must not reach the buffer
   wire push = slv_q == lan_host_pkg::S_SYNC && !rd_q && buf_rdy
      && !acc_end; // [RULE1] [RULE20]
   // Reads wait for queued writes so they never see stale data
   wire rd_go = slv_q == lan_host_pkg::S_SYNC && rd_q && cnt_q == 2'd0;
   // Register port busy while DMA engine owns the address registers
   wire pop_rdy = dma_q == lan_host_pkg::D_IDLE;
   wire pop = cnt_q != 2'd0 && pop_rdy;
   lan_host_pkg::reg_wr_t head;
   assign head = buf_q[rptr_q];
   wire wr_cmd = pop && head.addr == lan_host_pkg::REG_CMD;
   wire wr_isr = pop && head.addr == lan_host_pkg::REG_ISR;
   wire wr_imr = pop && head.addr == lan_host_pkg::REG_IMR;
   wire wr_dcr = pop && head.addr == lan_host_pkg::REG_DCR;
   wire wr_tcr = pop && head.addr == lan_host_pkg::REG_TCR;
   wire wr_rlo = pop && head.addr == lan_host_pkg::REG_REMOTE_LO;
   wire wr_rhi = pop && head.addr == lan_host_pkg::REG_REMOTE_HI;
   wire [7:0] rd_val = rd_mux(acc_q.addr, cmd_q, isr_q, imr_q, dcr_q,
      tcr_q, remote_lo_q, remote_hi_q); // [RULE2]
   wire start_on = cmd_q[lan_host_pkg::CMD_START_BIT];
   wire long_addr = dcr_q[lan_host_pkg::DCR_LONG_ADDR_BIT];

   // Interrupt status: set wins over clear
   always_comb begin
      isr_set = 8'h00;
      isr_set[lan_host_pkg::ISR_RX_BIT] = EV_RX;
      isr_set[lan_host_pkg::ISR_TX_BIT] = EV_TX;
      isr_set[lan_host_pkg::ISR_DMA_BIT] = EV_DMA;
      isr_clr = wr_isr ? head.data : 8'h00;
      isr_d = (isr_q & ~isr_clr) | isr_set; // [RULE7]
   end
   wire [7:0] imr_d = wr_imr ? head.data : imr_q;
   wire int_d = |(isr_d & imr_d); // [RULE8]

   // Slave state machine
   always_comb begin
      slv_d = slv_q;
      unique case (slv_q)
         lan_host_pkg::S_IDLE: if (acc_start) slv_d = lan_host_pkg::S_SYNC;
         lan_host_pkg::S_SYNC: begin
            if (acc_end) slv_d = lan_host_pkg::S_IDLE;
            else if (push || rd_go) slv_d = lan_host_pkg::S_ACK; // [RULE3]
         end
         lan_host_pkg::S_ACK: if (acc_end) slv_d = lan_host_pkg::S_IDLE;
         default: slv_d = lan_host_pkg::S_IDLE;
      endcase
   end

   // DMA pending work and cycle sequencing
   wire any_pend = FIFO_REQ || wr_pend_q || rd_pend_q;
   wire dma_end = dma_q == lan_host_pkg::D_T4;
   always_comb begin
      dma_d = dma_q;
      kind_d = kind_q;
      unique case (dma_q)
         lan_host_pkg::D_IDLE: begin
            if (BUS_REQUEST && BACK && any_pend) begin // [RULE13]
               dma_d = lan_host_pkg::D_T1;
               if (wr_pend_q) kind_d = lan_host_pkg::K_RWR;
               else if (rd_pend_q) kind_d = lan_host_pkg::K_RRD;
               else kind_d = lan_host_pkg::K_LOCAL;
            end
         end
         lan_host_pkg::D_T1: dma_d = lan_host_pkg::D_T2; // [RULE21]
         lan_host_pkg::D_T2: dma_d = lan_host_pkg::D_T3;
         lan_host_pkg::D_T3, lan_host_pkg::D_TW:
            dma_d = READY ? lan_host_pkg::D_TW : lan_host_pkg::D_T4; // [RULE19]
         lan_host_pkg::D_T4: dma_d = lan_host_pkg::D_IDLE;
         default: dma_d = lan_host_pkg::D_IDLE;
      endcase
   end
   wire in_data = dma_d == lan_host_pkg::D_T2 || dma_d == lan_host_pkg::D_T3
      || dma_d == lan_host_pkg::D_TW || dma_d == lan_host_pkg::D_T4;
   wire port_rd_d = in_data && kind_d == lan_host_pkg::K_RWR; // [RULE5]
   // Request drops when work runs out, so a looped grant releases
   wire req_d = start_on && (any_pend
      || dma_q != lan_host_pkg::D_IDLE); // [RULE9] [RULE12] [RULE14]
   wire port_req_d = REMOTE_ACTIVE && !wr_pend_q && !rd_pend_q
      && dma_q == lan_host_pkg::D_IDLE; // [RULE17]
   wire ads_d = dma_d == lan_host_pkg::D_T1 && BACK; // [RULE15]
   wire pin_d = long_addr ? ads_d : port_req_d;
   wire pin_oe_d = dcr_prog_q && (!long_addr || BACK); // [RULE16] [RULE18]

   // Two-entry write buffer
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wptr_q <= 1'b0;
         rptr_q <= 1'b0;
         cnt_q <= 2'd0;
      end else if (CE) begin
         if (push) wptr_q <= !wptr_q;
         if (pop) rptr_q <= !rptr_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
   always_ff @(posedge CLK) begin
      if (CE && push) buf_q[wptr_q] <= acc_q;
   end

   // Access capture; address ignored unless selected
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         slv_q <= lan_host_pkg::S_IDLE;
         acc_q <= '0;
         rd_q <= 1'b0;
      end else if (CE) begin
         slv_q <= slv_d;
         if (slv_q == lan_host_pkg::S_IDLE && acc_start) begin // [RULE4]
            acc_q.addr <= REGISTER_SELECT;
            acc_q.data <= AD_IN;
            rd_q <= !SLAVE_READ_STROBE_N;
         end
      end
   end

   // Register file; async reset finishes well inside ten clocks
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin // [RULE10] [RULE11]
         cmd_q <= lan_host_pkg::CMD_RST;
         isr_q <= lan_host_pkg::ISR_RST;
         imr_q <= lan_host_pkg::IMR_RST;
         dcr_q <= lan_host_pkg::DCR_RST;
         tcr_q <= lan_host_pkg::TCR_RST;
         remote_lo_q <= lan_host_pkg::RSAR_RST;
         remote_hi_q <= lan_host_pkg::RSAR_RST;
         dcr_prog_q <= 1'b0;
      end else if (CE) begin
         isr_q <= isr_d;
         imr_q <= imr_d;
         if (wr_cmd) cmd_q <= head.data; // [RULE1] [RULE9]
         if (wr_dcr) dcr_q <= head.data;
         if (wr_dcr) dcr_prog_q <= 1'b1; // [RULE18]
         if (wr_tcr) tcr_q <= head.data;
         if (wr_rlo) remote_lo_q <= head.data;
         if (wr_rhi) remote_hi_q <= head.data;
      end
   end

   // DMA state and latch handshakes; set wins over clear
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         dma_q <= lan_host_pkg::D_IDLE;
         kind_q <= lan_host_pkg::K_LOCAL;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
      end else if (CE) begin
         dma_q <= dma_d;
         kind_q <= kind_d;
         if (LATCH_WRITE_ACK) wr_pend_q <= 1'b1; // [RULE6]
         else if (dma_end && kind_q == lan_host_pkg::K_RWR)
            wr_pend_q <= 1'b0;
         if (LATCH_READ_ACK) rd_pend_q <= 1'b1; // [RULE22]
         else if (dma_end && kind_q == lan_host_pkg::K_RRD)
            rd_pend_q <= 1'b0;
      end
   end

   // Registered outputs
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         AD_OUT <= 8'h00;
         AD_OE <= 1'b0;
         ACK_N <= 1'b1;
         INT <= 1'b0;
         TXRX_ENABLE <= 1'b0;
         BUS_REQUEST <= 1'b0;
         PORT_READ_ENABLE <= 1'b0;
         SHARED_PIN_O <= 1'b0;
         SHARED_PIN_OE <= 1'b0;
         UPPER_ADDR <= 16'h0000;
         DMA_KIND <= 2'b00;
         DMA_DONE <= 1'b0;
      end else if (CE) begin
         if (rd_go && !acc_end) AD_OUT <= rd_val; // [RULE2]
         AD_OE <= slv_d == lan_host_pkg::S_ACK && rd_q;
         ACK_N <= slv_d != lan_host_pkg::S_ACK; // [RULE3] [RULE23]
         INT <= int_d; // [RULE7] [RULE8]
         TXRX_ENABLE <= wr_cmd ? head.data[lan_host_pkg::CMD_START_BIT]
            : start_on; // [RULE9]
         BUS_REQUEST <= req_d; // [RULE12]
         PORT_READ_ENABLE <= port_rd_d; // [RULE5]
         SHARED_PIN_O <= pin_d; // [RULE15] [RULE17]
         SHARED_PIN_OE <= pin_oe_d; // [RULE16] [RULE18]
         UPPER_ADDR <= {remote_hi_q, remote_lo_q}; // [RULE15]
         DMA_KIND <= kind_d;
         DMA_DONE <= dma_end;
      end
   end

   AST_ACK_WAIT: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && slv_q == lan_host_pkg::S_IDLE && acc_start |=> ACK_N) // [RULE3]
      else $error("ack granted before sync");
   AST_READ_GRANT: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && rd_go && !acc_end |=> !ACK_N && AD_OE && AD_OUT == $past(rd_val))
      else $error("read not granted with data"); // [RULE2]
   AST_ACK_RELEASE: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && slv_q == lan_host_pkg::S_ACK && acc_end |=> ACK_N) // [RULE23]
      else $error("ack not released");
   AST_CS_IGNORE: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && CS_N && slv_q == lan_host_pkg::S_IDLE
      |=> slv_q == lan_host_pkg::S_IDLE && $stable(acc_q)) // [RULE4]
      else $error("access taken without chip select");
   AST_IMR_STORE: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && wr_imr |=> imr_q == $past(head.data)) // [RULE1]
      else $error("mask write lost");
   AST_MASKED: assert property (@(posedge CLK) disable iff (!RST_N)
      imr_q == 8'h00 |-> !INT) // [RULE8]
      else $error("masked interrupt seen");
   AST_ISR_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && wr_isr && isr_set == 8'h00
      |=> (isr_q & $past(head.data)) == 8'h00) // [RULE7]
      else $error("status not cleared");
   AST_NO_GRANT: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && dma_q == lan_host_pkg::D_IDLE && !BACK
      |=> dma_q == lan_host_pkg::D_IDLE) // [RULE13]
      else $error("master cycle without grant");
   AST_T_SEQ: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && dma_q == lan_host_pkg::D_T1 && CE
      |=> dma_q == lan_host_pkg::D_T2) // [RULE21]
      else $error("cycle order broken");
   AST_READY_WAIT: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && dma_q == lan_host_pkg::D_T3 && READY
      |=> dma_q == lan_host_pkg::D_TW) // [RULE19]
      else $error("ready ignored");
   AST_PORT_READ: assert property (@(posedge CLK) disable iff (!RST_N)
      kind_q == lan_host_pkg::K_RWR && dma_q == lan_host_pkg::D_T3
      |-> PORT_READ_ENABLE) // [RULE5]
      else $error("port read missing");
   AST_PIN_FLOAT: assert property (@(posedge CLK) disable iff (!RST_N)
      !dcr_prog_q |-> !SHARED_PIN_OE) // [RULE18]
      else $error("shared pin driven early");
   AST_NO_START: assert property (@(posedge CLK) disable iff (!RST_N)
      !start_on && $past(!start_on) |-> !BUS_REQUEST) // [RULE9]
      else $error("request while stopped");
   COV_READ: cover property (@(posedge CLK) rd_go ##1 !ACK_N);
   COV_WAIT: cover property (@(posedge CLK)
      dma_q == lan_host_pkg::D_T3 ##1 dma_q == lan_host_pkg::D_TW);
   COV_FULL: cover property (@(posedge CLK) cnt_q == 2'd2);
   COV_RWR: cover property (@(posedge CLK) PORT_READ_ENABLE ##1 DMA_DONE);
endmodule : lan_host_port
`default_nettype wire

// *** tb/lan_host_far.sv ***
// Bus arbiter and buffer memory model on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module lan_host_far (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SLOW,
   input wire logic BUS_REQUEST,
   input wire logic PORT_READ_ENABLE,
   output logic BACK,
   output logic READY
);
   logic back_q;
   logic ready_q;
   logic seen_q;
   // Request looped to grant; slow mode grants a clock late
   assign BACK = SLOW ? back_q : BUS_REQUEST;
   assign READY = ready_q;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         back_q <= 1'b0;
         ready_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         back_q <= BUS_REQUEST;
         // In slow mode, one wait state per memory write, seen at t3
         ready_q <= SLOW & PORT_READ_ENABLE & ~seen_q;
         seen_q <= PORT_READ_ENABLE;
      end
   end
endmodule : lan_host_far
`default_nettype wire

// *** tb/lan_host_port_bench.sv ***
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module lan_host_port_bench;
   logic clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
   logic fifo_req = 1'b0, remote = 1'b0, slow = 1'b0, ce = 1'b1, hi, br;
   logic oe, ack_n, irq, txrx, bus_req, back, ready, pre, pin_o, pin_oe;
   logic done;
   logic [4:0] pls = 5'h00;
   logic [3:0] sel = 4'h0;
   logic [7:0] din = 8'h00;
   logic [7:0] dout, v;
   logic [15:0] upper;
   logic [1:0] kind;
   int bad_count = 0, comparisons = 0, n;
   lan_host_port dut_u (.CLK(clk), .RST_N(rst_n), .CE(ce), .CS_N(cs_n),
      .SLAVE_WRITE_STROBE_N(wr_n), .SLAVE_READ_STROBE_N(rd_n),
      .REGISTER_SELECT(sel), .AD_IN(din), .AD_OUT(dout), .AD_OE(oe),
      .ACK_N(ack_n), .EV_RX(pls[0]), .EV_TX(pls[1]), .EV_DMA(pls[2]),
      .INT(irq), .TXRX_ENABLE(txrx), .FIFO_REQ(fifo_req),
      .REMOTE_ACTIVE(remote), .BUS_REQUEST(bus_req), .BACK(back),
      .READY(ready), .LATCH_WRITE_ACK(pls[3]), .LATCH_READ_ACK(pls[4]),
      .PORT_READ_ENABLE(pre), .SHARED_PIN_O(pin_o),
      .SHARED_PIN_OE(pin_oe),
      .UPPER_ADDR(upper), .DMA_KIND(kind), .DMA_DONE(done));
   lan_host_far far_u (.CLK(clk), .RST_N(rst_n), .SLOW(slow),
      .BUS_REQUEST(bus_req), .PORT_READ_ENABLE(pre), .BACK(back),
      .READY(ready));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic chk(input string s, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("counts %0d compared %0d bad", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   // Held until acknowledge is sampled low, so no wait state is cut short
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
      int i;
      @(posedge clk);
      cs_n <= 1'b0;
      sel <= a;
      din <= d;
      wr_n <= ~w;
      rd_n <= w;
      for (i = 0; i < 20 && ack_n !== 1'b0; i++) @(posedge clk);
      chk("ack_n low", 1'b0, ack_n);
      v = dout;
      if (!w) chk("oe", 1'b1, oe);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      for (i = 0; i < 20 && ack_n !== 1'b1; i++) @(posedge clk);
      chk("ack_n high", 1'b1, ack_n);
      @(posedge clk);
   endtask : acc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk("reg", e, v);
   endtask : rd
   task automatic pulse(input int k);
      @(posedge clk);
      pls[k] <= 1'b1;
      @(posedge clk);
      pls <= 5'h00;
   endtask : pulse
   task automatic wait_int(input logic e);
      int i;
      for (i = 0; i < 6 && irq !== e; i++) @(posedge clk);
      chk("int", e, irq);
   endtask : wait_int
   // Kind 3 remote write, 4 remote read, 0 local FIFO service
   task automatic dma(input int k, output int p);
      int i;
      p = 0;
      hi = 1'b0;
      br = 1'b0;
      if (k > 0) pulse(k);
      else fifo_req <= 1'b1;
      for (i = 0; i < 60 && done !== 1'b1; i++) begin
         @(posedge clk);
         p += int'(pre);
         hi |= pin_o & pin_oe;
         br |= bus_req;
      end
      fifo_req <= 1'b0;
      chk("done", 1'b1, done);
      chk("bus_req", 1'b1, br);
      chk("kind", 16'(k == 3 ? 1 : k == 4 ? 2 : 0), kind);
      repeat (4) @(posedge clk);
   endtask : dma
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      test_done;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      chk("ack_n", 1'b1, ack_n);
      chk("txrx", 1'b0, txrx);
      chk("pin_oe", 1'b0, pin_oe);
      rd(lan_host_pkg::REG_CMD, lan_host_pkg::CMD_RST);
      rd(lan_host_pkg::REG_IMR, lan_host_pkg::IMR_RST);
      rd(lan_host_pkg::REG_DCR, lan_host_pkg::DCR_RST);
      rd(lan_host_pkg::REG_TCR, lan_host_pkg::TCR_RST);
      $display("test reset done");
      sel <= lan_host_pkg::REG_TCR;
      din <= 8'h5A;
      wr_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk("ack_n", 1'b1, ack_n);
      wr_n <= 1'b1;
      rd(lan_host_pkg::REG_TCR, lan_host_pkg::TCR_RST);
      wr(lan_host_pkg::REG_TCR, 8'hA5);
      rd(lan_host_pkg::REG_TCR, 8'hA5);
      wr(4'h4, 8'hFF);
      rd(4'h4, 8'h00);
      // Strobe dropped before acknowledge: access abandoned
      @(posedge clk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      sel <= lan_host_pkg::REG_TCR;
      din <= 8'h77;
      @(posedge clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("ack_n", 1'b1, ack_n);
      rd(lan_host_pkg::REG_TCR, 8'hA5);
      $display("test access done");
      wr(lan_host_pkg::REG_IMR, 8'h41);
      pulse(1);
      repeat (4) @(posedge clk);
      chk("int", 1'b0, irq);
      pulse(0);
      wait_int(1'b1);
      rd(lan_host_pkg::REG_ISR, 8'h03);
      wr(lan_host_pkg::REG_ISR, 8'h01);
      wait_int(1'b0);
      pulse(2);
      wait_int(1'b1);
      wr(lan_host_pkg::REG_ISR, 8'h42);
      wait_int(1'b0);
      // Events during a frozen clock enable are lost
      ce <= 1'b0;
      pulse(0);
      repeat (2) @(posedge clk);
      chk("int frozen", 1'b0, irq);
      ce <= 1'b1;
      rd(lan_host_pkg::REG_ISR, 8'h00);
      $display("test interrupt done");
      pulse(3);
      repeat (8) @(posedge clk);
      chk("bus_req", 1'b0, bus_req);
      wr(lan_host_pkg::REG_CMD, 8'h02);
      chk("txrx", 1'b1, txrx);
      remote <= 1'b1;
      wr(lan_host_pkg::REG_DCR, 8'h00);
      repeat (30) @(posedge clk);
      chk("pin_oe", 1'b1, pin_oe);
      chk("port req", 1'b1, pin_o);
      dma(3, n);
      chk("pre cycles", 16'd3, 16'(n));
      dma(4, n);
      chk("pre cycles", 16'd0, 16'(n));
      dma(0, n);
      slow <= 1'b1;
      dma(3, n);
      chk("pre cycles", 16'd4, 16'(n));
      $display("test dma done");
      wr(lan_host_pkg::REG_REMOTE_LO, 8'h34);
      wr(lan_host_pkg::REG_REMOTE_HI, 8'h12);
      wr(lan_host_pkg::REG_DCR, 8'h08);
      @(posedge clk);
      chk("upper", 16'h1234, upper);
      chk("pin_oe", 1'b0, pin_oe);
      dma(3, n);
      chk("strobe", 1'b1, hi);
      $display("test long address done");
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk("txrx", 1'b0, txrx);
      chk("pin_oe", 1'b0, pin_oe);
      rst_n <= 1'b1;
      rd(lan_host_pkg::REG_DCR, lan_host_pkg::DCR_RST);
      $display("test second reset done");
      test_done;
   end
endmodule : lan_host_port_bench
`default_nettype wire
